/* File: logic/tg_pkg.sv */
// Shared constants for the four-channel timed gate and its crate controller.
package tg_pkg;
  // ----------------------------------------------------------------------
  // Channel and counter geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NCH      = 4;   // Number of timing channels.
  localparam int unsigned DUR_W    = 20;  // Width of a gate length.
  localparam int unsigned SEL_W    = 2;   // Width of a tick rate code.
  localparam int unsigned DW_W     = 24;  // Width of Dataway R and W lines.
  localparam int unsigned PRE_W    = 10;  // Width of a channel prescaler.
  // Divide ratios of the base tick, by tick rate code.
  localparam logic [PRE_W-1:0] DIV_1    = 10'h001;
  localparam logic [PRE_W-1:0] DIV_10   = 10'h00a;
  localparam logic [PRE_W-1:0] DIV_100  = 10'h064;
  localparam logic [PRE_W-1:0] DIV_1000 = 10'h3e8;
  // Identity value returned on the identity read; the value is arbitrary.
  localparam logic [11:0] BOARD_IDENTITY = 12'h5a3;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;    // pclk period.
  localparam int unsigned DONE_HIGH_NS  = 1000;  // Done pulse high time.
  localparam int unsigned DONE_CYCLES   = DONE_HIGH_NS / CLK_PERIOD_NS;
  localparam int unsigned BASE_TICK_NS  = 1000;  // Base tick period.
  localparam int unsigned BASE_HALF_CYC = BASE_TICK_NS / CLK_PERIOD_NS / 2;
  // ----------------------------------------------------------------------
  // Dataway function codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] F_RD_FLAGS  = 5'h00;
  localparam logic [4:0] F_RD_LEN    = 5'h01;
  localparam logic [4:0] F_RD_RATE   = 5'h02;
  localparam logic [4:0] F_RD_ID     = 5'h06;
  localparam logic [4:0] F_WR_LEN    = 5'h10;
  localparam logic [4:0] F_WR_RATE   = 5'h11;
  localparam logic [4:0] F_TRIG      = 5'h12;
  localparam logic [4:0] F_ENABLE    = 5'h13;
  localparam logic [4:0] F_LOAD_GO   = 5'h14;
  localparam logic [4:0] F_STOP      = 5'h15;
  localparam logic [4:0] F_DISABLE   = 5'h16;
  localparam logic [4:0] F_ENA_ALL   = 5'h1a;
  // ----------------------------------------------------------------------
  // Controller APB register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;  // Command launch register.
  localparam logic [7:0] OFS_WDATA  = 8'h04;  // Write data for W lines.
  localparam logic [7:0] OFS_RDATA  = 8'h08;  // Captured R lines.
  localparam logic [7:0] OFS_STATUS = 8'h0c;  // Busy, Q and X.
  localparam int unsigned CMD_F_LSB = 0;   // Function code, bits 4:0.
  localparam int unsigned CMD_A_LSB = 8;   // Subaddress, bits 11:8.
  localparam int unsigned CMD_N_BIT = 16;  // Station select.
  localparam int unsigned CMD_Z_BIT = 17;  // Initialize.
  localparam int unsigned CMD_C_BIT = 18;  // Clear.
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_Q      = 1;
  localparam int unsigned ST_X      = 2;
endpackage : tg_pkg

/* File: logic/tg_dataway_if.sv */
// Dataway connection between the crate controller and the timed gate.
`timescale 1ns/1ps
`default_nettype none
interface tg_dataway_if;
  logic        cmd_strobe;      // One-cycle command strobe.
  logic        station_n;       // Station select for this module.
  logic [3:0]  sub_a;           // Subaddress.
  logic [4:0]  func_f;          // Function code.
  logic [23:0] wr_w;            // Write lines.
  logic        init_z;          // Initialize, qualified by the strobe.
  logic        clear_c;         // Clear, qualified by the strobe.
  logic        base_tick_line;  // 1 MHz base tick level.
  logic [23:0] rd_r;            // Read lines.
  logic        resp_q;          // Q answer.
  logic        resp_x;          // X answer.
  logic        resp_valid;      // One-cycle answer marker.
  modport ctrl (output cmd_strobe, station_n, sub_a, func_f, wr_w, init_z,
                clear_c, base_tick_line,
                input rd_r, resp_q, resp_x, resp_valid);
  modport dev (input cmd_strobe, station_n, sub_a, func_f, wr_w, init_z,
               clear_c, base_tick_line,
               output rd_r, resp_q, resp_x, resp_valid);
endinterface : tg_dataway_if
`default_nettype wire

/* File: logic/tg_gate_device.sv */
// Four-channel timed gate: Dataway command decode and channel timing.
`timescale 1ns/1ps
`default_nettype none
module tg_gate_device (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  tg_dataway_if.dev                    dw,
  input  wire logic [tg_pkg::NCH-1:0]  trig_in,
  input  wire logic                    stop_in,
  input  wire logic [tg_pkg::NCH-1:0]  retrig_strap,
  output logic      [tg_pkg::NCH-1:0]  gate_out,
  output logic      [tg_pkg::NCH-1:0]  gate_done_pulse
);
  import tg_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [NCH:0]       sync1_r;     // First synchroniser stage.
  logic [NCH:0]       sync2_r;     // Second synchroniser stage.
  logic [NCH:0]       sync3_r;     // Delayed copy for edge detection.
  logic [NCH:0]       ext_edge;    // Rising edges, stop in the top bit.
  logic               tick_d_r;    // Previous base tick level.
  logic               base_tick;   // One-cycle pulse per base tick.
  logic               cmd;         // Addressed command this cycle.
  logic               zc;          // Initialize or clear this cycle.
  logic               ch_ok;       // Subaddress names a channel.
  logic [1:0]         ch;          // Selected channel.
  logic               a_zero;      // Subaddress is zero.
  logic [NCH-1:0]     on_r;        // Channel ON state.
  logic [NCH-1:0]     en_r;        // Channel enables.
  logic [DUR_W-1:0]   len_r [NCH]; // Gate lengths.
  logic [SEL_W-1:0]   rate_r [NCH];// Tick rate codes.
  logic [DUR_W-1:0]   cnt_r [NCH]; // Remaining selected-clock periods.
  logic [PRE_W-1:0]   pre_r [NCH]; // Per-channel prescaler.
  logic [4:0]         done_cnt_r [NCH]; // Done pulse length counters.
  logic [NCH-1:0]     trig_dw;     // Dataway trigger request.
  logic [NCH-1:0]     trig_ok;     // Trigger accepted.
  logic [NCH-1:0]     blocked;     // Trigger refused while ON without strap.
  logic [NCH-1:0]     stop_sel;    // Selective stop request.
  logic [NCH-1:0]     expire;      // Count ran out this cycle.
  logic [NCH-1:0]     done_start;  // Start of a done pulse.

  // Divide ratio for a tick rate code.
  function automatic logic [PRE_W-1:0] div_of(input logic [SEL_W-1:0] c);
    unique case (c)
      2'h0: div_of = DIV_1;
      2'h1: div_of = DIV_10;
      2'h2: div_of = DIV_100;
      2'h3: div_of = DIV_1000;
    endcase
  endfunction : div_of

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  // Triggers and stop pass two flops, then a third flop for the edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= {stop_in, trig_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign ext_edge = sync2_r & ~sync3_r;

  // The base tick is synchronous; its rising edge marks one period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= dw.base_tick_line;
    end
  end
  assign base_tick = dw.base_tick_line & ~tick_d_r;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  assign cmd    = dw.cmd_strobe & dw.station_n;
  assign zc     = dw.cmd_strobe & (dw.init_z | dw.clear_c);
  assign ch_ok  = (dw.sub_a[3:2] == 2'b00);
  assign ch     = dw.sub_a[1:0];
  assign a_zero = (dw.sub_a == 4'h0);

  // Per-channel request decode.
  for (genvar i = 0; i < NCH; i++) begin : g_dec
    logic sel_i; // Subaddress selects this channel.
    logic ext_i; // Enabled external trigger request.
    assign sel_i = ch_ok && (ch == 2'(i));
    assign trig_dw[i] = cmd && ((dw.func_f == F_TRIG && a_zero && dw.wr_w[i])
                        || (dw.func_f == F_LOAD_GO && sel_i));
    assign ext_i = ext_edge[i] & en_r[i];
    // ON without strap refuses any trigger; strap accepts all.
    assign blocked[i] = on_r[i] & ~retrig_strap[i];
    assign trig_ok[i] = (trig_dw[i] | ext_i) & ~blocked[i];
    assign stop_sel[i] = cmd && dw.func_f == F_STOP && a_zero && dw.wr_w[i];
    assign expire[i] = on_r[i] && base_tick && (cnt_r[i] <= 20'h00001)
                       && (pre_r[i] == div_of(rate_r[i]) - 10'h001);
  end

  // ----------------------------------------------------------------------
  // Channel state
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Gate length and tick rate are written only by Dataway commands.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        len_r[i]  <= '0;
        rate_r[i] <= '0;
      end else if (cmd && ch_ok && ch == 2'(i)) begin
        if (dw.func_f == F_WR_LEN ||
            (dw.func_f == F_LOAD_GO && !blocked[i])) begin
          len_r[i] <= dw.wr_w[DUR_W-1:0];
        end
        if (dw.func_f == F_WR_RATE) begin
          rate_r[i] <= dw.wr_w[SEL_W-1:0];
        end
      end
    end

    // Enable: cleared by reset, Z, C or disable; set by enable commands and accepted Dataway triggers.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        en_r[i] <= 1'b0;
      end else if (zc) begin
        en_r[i] <= 1'b0;
      end else if ((trig_dw[i] && !blocked[i]) ||
                   (cmd && a_zero && ((dw.func_f == F_ENABLE && dw.wr_w[i])
                                      || dw.func_f == F_ENA_ALL))) begin
        en_r[i] <= 1'b1;
      end else if (cmd && a_zero && dw.func_f == F_DISABLE && dw.wr_w[i]) begin
        en_r[i] <= 1'b0;
      end
    end

    // ON state, remaining count and prescaler.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        on_r[i]  <= 1'b0;
        cnt_r[i] <= '0;
        pre_r[i] <= '0;
      end else if (zc || ext_edge[NCH]) begin
        on_r[i] <= 1'b0;
      end else if (stop_sel[i]) begin
        on_r[i] <= 1'b0;
      end else if (trig_ok[i]) begin
        // Restart from the full length whether OFF or ON.
        on_r[i]  <= 1'b1;
        cnt_r[i] <= (dw.func_f == F_LOAD_GO && trig_dw[i])
                    ? dw.wr_w[DUR_W-1:0] : len_r[i];
        pre_r[i] <= '0;
      end else if (on_r[i] && cnt_r[i] == '0) begin
        on_r[i] <= 1'b0; // A zero length ends at once.
      end else if (expire[i]) begin
        on_r[i] <= 1'b0;
      end else if (on_r[i] && base_tick) begin
        // Divide the base tick per channel so the phase starts at trigger.
        if (pre_r[i] == div_of(rate_r[i]) - 10'h001) begin
          pre_r[i] <= '0;
          cnt_r[i] <= cnt_r[i] - 20'h00001;
        end else begin
          pre_r[i] <= pre_r[i] + 10'h001;
        end
      end
    end

    // A done pulse starts when ON drops for any cause but the external stop, Z, C, or a selective stop in the cycle of an accepted external trigger.
    assign done_start[i] = on_r[i] && !zc && !ext_edge[NCH] && !trig_ok[i]
                           && (stop_sel[i] || cnt_r[i] == '0 || expire[i]);

    // Done pulse lasts a fixed number of cycles.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        done_cnt_r[i] <= '0;
      end else if (done_start[i]) begin
        done_cnt_r[i] <= 5'(DONE_CYCLES);
      end else if (done_cnt_r[i] != '0) begin
        done_cnt_r[i] <= done_cnt_r[i] - 5'h01;
      end
    end

    // Gate and done outputs come straight from flops.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gate_done_pulse[i] <= 1'b0;
      end else begin
        gate_done_pulse[i] <= (done_cnt_r[i] != '0);
      end
    end
  end
  assign gate_out = on_r;

  // ----------------------------------------------------------------------
  // Dataway answer
  // ----------------------------------------------------------------------
  // Every strobe is answered one cycle later with R, Q and X.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dw.rd_r       <= '0;
      dw.resp_q     <= 1'b0;
      dw.resp_x     <= 1'b0;
      dw.resp_valid <= 1'b0;
    end else begin
      dw.resp_valid <= dw.cmd_strobe;
      dw.rd_r       <= '0;
      dw.resp_q     <= 1'b0;
      dw.resp_x     <= zc;
      if (cmd) begin
        unique case (dw.func_f)
          F_RD_FLAGS: if (ch_ok) begin
            dw.rd_r[2:0] <= {retrig_strap[ch], en_r[ch], on_r[ch]};
            dw.resp_q    <= 1'b1;
            dw.resp_x    <= 1'b1;
          end
          F_RD_LEN: if (ch_ok) begin
            dw.rd_r[DUR_W-1:0] <= len_r[ch];
            dw.resp_q          <= 1'b1;
            dw.resp_x          <= 1'b1;
          end
          F_RD_RATE: if (ch_ok) begin
            dw.rd_r[SEL_W-1:0] <= rate_r[ch];
            dw.resp_q          <= 1'b1;
            dw.resp_x          <= 1'b1;
          end
          F_RD_ID: if (a_zero) begin
            dw.rd_r[11:0] <= BOARD_IDENTITY;
            dw.resp_q     <= 1'b1;
            dw.resp_x     <= 1'b1;
          end
          F_WR_LEN, F_WR_RATE: if (ch_ok) begin
            dw.resp_q <= 1'b1;
            dw.resp_x <= 1'b1;
          end
          F_LOAD_GO: if (ch_ok) begin
            dw.resp_q <= !blocked[ch];
            dw.resp_x <= 1'b1;
          end
          F_TRIG: if (a_zero) begin
            dw.resp_q <= ((dw.wr_w[NCH-1:0] & blocked) == '0);
            dw.resp_x <= 1'b1;
          end
          F_ENABLE, F_STOP, F_DISABLE, F_ENA_ALL: if (a_zero) begin
            dw.resp_q <= 1'b1;
            dw.resp_x <= 1'b1;
          end
          default: begin
            dw.resp_x <= zc;
          end
        endcase
      end
    end
  end
endmodule : tg_gate_device
`default_nettype wire

/* File: logic/tg_crate_ctrl.sv */
// Crate controller: APB registers to Dataway commands, and base tick.
`timescale 1ns/1ps
`default_nettype none
module tg_crate_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  tg_dataway_if.ctrl       dw
);
  import tg_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00, // Waiting for a launch.
    ST_ISSUE = 2'b01, // Strobe on the Dataway.
    ST_WAIT  = 2'b10  // Waiting for the answer.
  } tg_state_type;
  tg_state_type  state_r;     // Sequencer state.
  logic [31:0]   cmd_r;       // Last launched command word.
  logic [23:0]   wdata_r;     // Write data for the W lines.
  logic [23:0]   rdata_r;     // Captured R lines.
  logic          q_r;         // Captured Q.
  logic          x_r;         // Captured X.
  logic [4:0]    div_r;       // Base tick half-period counter.
  logic          wr_en;       // APB write completes this edge.
  logic          launch;      // Command register written while idle.

  assign wr_en  = psel & penable & pready & pwrite;
  assign launch = wr_en && paddr == OFS_CMD && state_r == ST_IDLE;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero-wait access: ready and read data are set in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          OFS_CMD:    prdata <= cmd_r;
          OFS_WDATA:  prdata <= {8'h00, wdata_r};
          OFS_RDATA:  prdata <= {8'h00, rdata_r};
          OFS_STATUS: prdata <= {29'h0, x_r, q_r, state_r != ST_IDLE};
          default:    prdata <= '0; // Unmapped reads return zero.
        endcase
      end
    end
  end

  // Software-written registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r   <= '0;
      wdata_r <= '0;
    end else begin
      if (launch) begin
        cmd_r <= pwdata;
      end
      if (wr_en && paddr == OFS_WDATA) begin
        wdata_r <= pwdata[23:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Dataway sequencer
  // ----------------------------------------------------------------------
  // One strobe per launch, then the answer is captured.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ST_IDLE;
      dw.cmd_strobe <= 1'b0;
      dw.station_n  <= 1'b0;
      dw.sub_a      <= '0;
      dw.func_f     <= '0;
      dw.wr_w       <= '0;
      dw.init_z     <= 1'b0;
      dw.clear_c    <= 1'b0;
      rdata_r       <= '0;
      q_r           <= 1'b0;
      x_r           <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (launch) begin
          state_r       <= ST_ISSUE;
          dw.cmd_strobe <= 1'b1;
          dw.func_f     <= pwdata[CMD_F_LSB +: 5];
          dw.sub_a      <= pwdata[CMD_A_LSB +: 4];
          dw.station_n  <= pwdata[CMD_N_BIT];
          dw.init_z     <= pwdata[CMD_Z_BIT];
          dw.clear_c    <= pwdata[CMD_C_BIT];
          dw.wr_w       <= wdata_r;
        end
        ST_ISSUE: begin
          state_r       <= ST_WAIT;
          dw.cmd_strobe <= 1'b0;
        end
        ST_WAIT: if (dw.resp_valid) begin
          state_r      <= ST_IDLE;
          rdata_r      <= dw.rd_r;
          q_r          <= dw.resp_q;
          x_r          <= dw.resp_x;
          dw.station_n <= 1'b0;
          dw.init_z    <= 1'b0;
          dw.clear_c   <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Base tick
  // ----------------------------------------------------------------------
  // Divide pclk down to the 1 MHz base tick, half period per toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r             <= '0;
      dw.base_tick_line <= 1'b0;
    end else if (div_r == 5'(BASE_HALF_CYC - 1)) begin
      div_r             <= '0;
      dw.base_tick_line <= ~dw.base_tick_line;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
endmodule : tg_crate_ctrl
`default_nettype wire

/* File: tb/tg_chk.sv */
// Concurrent checks on the Dataway link and the gate outputs.
`timescale 1ns/1ps
`default_nettype none
module tg_chk
  import tg_pkg::*;
(
  input wire logic        pclk, presetn, cmd_strobe, station_n, init_z,
  input wire logic        clear_c, resp_q, resp_x, resp_valid,
  input wire logic [3:0]  sub_a, gate_out, gate_done_pulse,
  input wire logic [4:0]  func_f,
  input wire logic [23:0] wr_w, rd_r
);
  // --------------------------------------------------------------
  // Read answer of this station, not an initialize or clear.
  // --------------------------------------------------------------
  logic rd;
  assign rd = resp_valid && station_n && !init_z && !clear_c;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_answer_next: assert property (cmd_strobe |=> resp_valid)
    else $error("strobe not answered next cycle");
  a_answer_cause: assert property (resp_valid |-> $past(cmd_strobe))
    else $error("answer without strobe");
  a_fields_held: assert property (cmd_strobe |=>
    $stable({func_f, sub_a, wr_w}))
    else $error("command fields moved before answer");
  a_id_read: assert property (rd && func_f == F_RD_ID &&
    sub_a == 4'h0 |-> rd_r == {12'h000, BOARD_IDENTITY} && resp_q && resp_x)
    else $error("identity read wrong");
  a_flags_clean: assert property (rd && func_f == F_RD_FLAGS &&
    sub_a < 4 |-> rd_r[23:3] == 21'h0 && resp_q && resp_x)
    else $error("flags read wrong");
  a_len_clean: assert property (rd && func_f == F_RD_LEN &&
    sub_a < 4 |-> rd_r[23:20] == 4'h0 && resp_q && resp_x)
    else $error("length read wrong");
  a_rate_clean: assert property (rd && func_f == F_RD_RATE &&
    sub_a < 4 |-> rd_r[23:2] == 22'h0 && resp_q && resp_x)
    else $error("rate read wrong");
  a_done_width: assert property ($rose(gate_done_pulse[0]) |->
    gate_done_pulse[0][*8] ##1 gate_done_pulse[0][*8] ##1
    gate_done_pulse[0][*4] ##1 !gate_done_pulse[0]) else $error("done width");
  a_done_cause: assert property ($rose(gate_done_pulse[0]) |->
    $past(gate_out[0], 2) && !$past(gate_out[0])) else $error("stray done");
  a_clear_off: assert property (cmd_strobe && (init_z || clear_c) |=>
    gate_out == 4'h0) else $error("gate on after clear");
  c_id: cover property (rd && func_f == F_RD_ID);
  c_done: cover property ($rose(gate_done_pulse[0]));
  c_clear: cover property (cmd_strobe && clear_c);
endmodule : tg_chk
`default_nettype wire

/* File: tb/four_channel_timed_gate_test.sv */
// Self-checking bench for the timed gate and its crate controller.
`timescale 1ns/1ps
`default_nettype none
module four_channel_timed_gate_test;
  import tg_pkg::*;
  // --------------------------------------------------------------
  // Signals, ends and checker
  // --------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  trig_in, retrig_strap, gate_out, gate_done_pulse;
  logic [23:0] r;
  logic [1:0]  qx;
  int          miscompares, compares, n, e;
  tg_dataway_if dw_if ();
  tg_crate_ctrl i_tg_crate_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dw(dw_if));
  tg_gate_device i_tg_gate_device (.pclk(pclk), .presetn(presetn),
    .dw(dw_if), .trig_in(trig_in), .stop_in(stop_in), .gate_out(gate_out),
    .retrig_strap(retrig_strap), .gate_done_pulse(gate_done_pulse));
  tg_chk i_tg_chk (.pclk(pclk), .presetn(presetn), .gate_out(gate_out),
    .gate_done_pulse(gate_done_pulse), .cmd_strobe(dw_if.cmd_strobe),
    .station_n(dw_if.station_n), .init_z(dw_if.init_z), .rd_r(dw_if.rd_r),
    .clear_c(dw_if.clear_c), .resp_q(dw_if.resp_q), .resp_x(dw_if.resp_x),
    .resp_valid(dw_if.resp_valid), .sub_a(dw_if.sub_a),
    .func_f(dw_if.func_f), .wr_w(dw_if.wr_w));
  // --------------------------------------------------------------
  // Bus cycles, comparison and closing
  // --------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // An idle cycle keeps two calls from colliding.
  endtask : apb
  // Launches one command, waits for busy to drop, fetches Q, X and R.
  task automatic dw(input logic [4:0] f, input logic [3:0] a,
                    input logic [23:0] w, input logic [2:0] czn);
    logic [31:0] v;
    apb(1'b1, OFS_WDATA, {8'h00, w}, v);
    apb(1'b1, OFS_CMD, {13'h0000, czn, 4'h0, a, 3'h0, f}, v);
    do apb(1'b0, OFS_STATUS, 32'h0, v); while (v[0] !== 1'b0);
    qx = v[2:1];
    apb(1'b0, OFS_RDATA, 32'h0, v); r = v[23:0];
  endtask : dw
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      miscompares++; $display("unexpected at %0t: saw %h not %h", $time, s, x);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_off(input int c);
    n = 0;
    while (gate_out[c] === 1'b1 && n < 30000) begin @(posedge pclk); n++; end
  endtask : wait_off
  task automatic pulse(input int c);
    trig_in[c] <= 1'b1; repeat (20) @(posedge pclk);
    trig_in[c] <= 1'b0; repeat (6) @(posedge pclk);
  endtask : pulse
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    for (int c = 0; c < 4; c++) begin
      dw(F_RD_FLAGS, c[3:0], 24'h0, 3'b001);
      check({qx, r}, {2'b11, 21'h0, retrig_strap[c], 2'b00});
    end
    dw(F_RD_ID, 4'h0, 24'h0, 3'b001);
    check({qx, r}, {2'b11, 12'h000, BOARD_IDENTITY});
    dw(F_RD_ID, 4'h1, 24'h0, 3'b001);
    check({pslverr, qx}, 3'b000);
  endtask : t_reset
  // Each channel at its own rate code; ON time from a Dataway trigger.
  task automatic t_time();
    for (int c = 0; c < 4; c++) begin
      dw(F_WR_LEN, c[3:0], 24'hfffff, 3'b001);
      dw(F_RD_LEN, c[3:0], 24'h0, 3'b001);
      check(r, 24'hfffff);
      dw(F_WR_LEN, c[3:0], 24'(4 - c), 3'b001);
      dw(F_WR_RATE, c[3:0], 24'(c), 3'b001);
      dw(F_RD_RATE, c[3:0], 24'h0, 3'b001);
      check(r, c);
      dw(F_TRIG, 4'h0, 24'(1 << c), 3'b001); wait_off(c);
      e = (4 - c) * 20 * (c == 0 ? 1 : c == 1 ? 10 : c == 2 ? 100 : 1000);
      check(n <= e + 20 && n + 40 >= e, 1);
      @(posedge pclk); check(gate_done_pulse, 4'h1 << c);
      repeat (25) @(posedge pclk);
    end
  endtask : t_time
  task automatic t_ext();
    dw(5'h00, 4'h0, 24'h0, 3'b010); check(qx, 2'b10);
    pulse(1); check(gate_out, 4'h0);
    dw(F_ENABLE, 4'h0, 24'h2, 3'b001); pulse(1);
    check(gate_out, 4'h2);
    stop_in <= 1'b1; repeat (6) @(posedge pclk);
    check({gate_done_pulse, gate_out}, 8'h00);
    stop_in <= 1'b0; repeat (4) @(posedge pclk);
    dw(F_LOAD_GO, 4'h2, 24'h1, 3'b001);
    check({qx, gate_out}, 6'h34);
    dw(F_STOP, 4'h0, 24'h4, 3'b001);
    check({gate_done_pulse, gate_out}, 8'h40);
    dw(F_DISABLE, 4'h0, 24'h4, 3'b001);
    dw(F_RD_FLAGS, 4'h2, 24'h0, 3'b001);
    check(r, 24'h4);
    dw(F_ENA_ALL, 4'h0, 24'h0, 3'b001);
    dw(F_RD_FLAGS, 4'h2, 24'h0, 3'b001);
    check(r, 24'h6);
  endtask : t_ext
  task automatic t_retrig();
    dw(F_WR_LEN, 4'h0, 24'd10, 3'b001); dw(F_TRIG, 4'h0, 24'h3, 3'b001);
    check(qx, 2'b11);
    repeat (100) @(posedge pclk);
    dw(F_TRIG, 4'h0, 24'h1, 3'b001); check(qx, 2'b11);
    dw(F_TRIG, 4'h0, 24'h2, 3'b001); check({qx, gate_out}, 6'h23);
    wait_off(0); check(n > 150 && n <= 200, 1);
    dw(F_RD_FLAGS, 4'h1, 24'h0, 3'b001);
    check(r, 24'h3);
    dw(5'h00, 4'h0, 24'h0, 3'b100); check(gate_out, 4'h0);
    dw(F_RD_FLAGS, 4'h1, 24'h0, 3'b001);
    check(r, 24'h0);
  endtask : t_retrig
  // --------------------------------------------------------------
  // Clock, reset, main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, stop_in} = 5'h00;
    paddr = 8'h00; pwdata = 32'h0; trig_in = 4'h0; retrig_strap = 4'h5;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1; @(posedge pclk);
    t_reset(); t_time(); t_ext(); t_retrig();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++; end_of_test();
  end
endmodule : four_channel_timed_gate_test
`default_nettype wire
